// ==== rtl/stc_self_test_ctrl.sv ====
`timescale 1ns/1ps
module stc_self_test_ctrl #(
	parameter int OK_HALF  = stc_pkg::OK_HALF_CYC,
	parameter int ERR_HALF = stc_pkg::ERR_HALF_CYC,
	parameter logic [15:0] FW_VERSION = 16'h0001 // Arbitrary value
) (
	input  wire logic                        clk_sys,
	input  wire logic                        reset,
	// Power-up test engine handshake
	output logic                             postStart,
	output logic [stc_pkg::POST_IDX_W-1:0]   postIndex,
	input  wire logic                        postDone,
	input  wire logic                        postPass,
	// Conditional test results, pulse per failure
	input  wire logic [stc_pkg::COND_COUNT-1:0] condFail,
	input  wire logic                        condBusy,
	// Zeroization
	input  wire logic                        zeroReq,
	input  wire logic                        zeroDone,
	// Authentication
	input  wire logic                        authOk,
	input  wire logic [stc_pkg::ROLE_W-1:0]  authRole,
	input  wire logic                        logout,
	input  wire logic                        pwEncrypted,
	input  wire logic                        pwValid,
	output logic                             pwRefused,
	output logic [stc_pkg::ROLE_W-1:0]       activeRole,
	output logic                             serviceGrant,
	// Service request
	input  wire logic                        svcReq,
	input  wire logic                        svcProcessed,
	input  wire logic                        svcSecret,
	// Data path
	input  wire logic                        dataValid,
	input  wire logic [31:0]                 dataIn,
	output logic                             dataOutValid,
	output logic [31:0]                      dataOut,
	// Key generation and XTS key check
	input  wire logic                        keyGenValid,
	input  wire logic [stc_pkg::KEY_W-1:0]   genBits,
	output logic [stc_pkg::KEY_W-1:0]        symKey,
	input  wire logic                        xtsCheck,
	input  wire logic [stc_pkg::KEY_W-1:0]   xtsKeyA,
	input  wire logic [stc_pkg::KEY_W-1:0]   xtsKeyB,
	output logic                             xtsDone,
	output logic                             xtsAccept,
	// Firmware load
	input  wire logic                        fwLoadDone,
	input  wire logic                        fwSigOk,
	output logic                             fwExecEnable,
	// Host status and version
	input  wire logic                        versionReq,
	output logic                             versionValid,
	output logic [15:0]                      versionOut,
	output logic                             hostSelfTestOk,
	output logic                             errorFlag,
	output logic                             cryptoEnable,
	output logic                             statusLed
);
	stc_pkg::stc_state_t state;
	stc_pkg::stc_state_t next_state;
	logic [stc_pkg::POST_IDX_W-1:0] next_postIndex;
	logic next_postStart;
	logic next_hostSelfTestOk;
	logic next_errorFlag;
	logic next_cryptoEnable;
	logic [stc_pkg::ROLE_W-1:0] next_activeRole;
	logic next_serviceGrant;
	logic next_pwRefused;
	logic next_dataOutValid;
	logic [31:0] next_dataOut;
	logic [stc_pkg::KEY_W-1:0] next_symKey;
	logic next_fwExecEnable;
	logic next_versionValid;
	logic [15:0] next_versionOut;
	logic outOpen;
	logic ledOn;
	logic ledFast;
	logic keyDone;
	logic keyAccept;

	always_comb
	begin
		next_state          = state;
		next_postIndex      = postIndex;
		next_postStart      = 1'b0;
		next_hostSelfTestOk = hostSelfTestOk;
		next_errorFlag      = errorFlag;
		unique case (state)
			stc_pkg::STC_RESET:
			begin
				next_state     = stc_pkg::STC_POST;
				next_postIndex = stc_pkg::POST_FW_HASH;
				next_postStart = 1'b1;
			end
			stc_pkg::STC_POST:
				if (postDone)
				begin
					if (!postPass)
						next_state = stc_pkg::STC_ERROR;
					else if (postIndex == stc_pkg::POST_LAST)
					begin
						next_state          = stc_pkg::STC_READY;
						next_hostSelfTestOk = 1'b1;
					end
					else
					begin
						next_postIndex = postIndex + 1'b1;
						next_postStart = 1'b1;
					end
				end
			stc_pkg::STC_READY:
				if (|condFail || (fwLoadDone && !fwSigOk))
					next_state = stc_pkg::STC_ERROR;
				else if (zeroReq)
					next_state = stc_pkg::STC_ZERO;
			stc_pkg::STC_ZERO:
				if (|condFail)
					next_state = stc_pkg::STC_ERROR;
				else if (zeroDone)
					next_state = stc_pkg::STC_READY;
			stc_pkg::STC_ERROR:
				next_state = stc_pkg::STC_ERROR;
			default:
				next_state = stc_pkg::STC_ERROR;
		endcase
		if (next_state == stc_pkg::STC_ERROR)
		begin
			next_errorFlag      = 1'b1;
			next_hostSelfTestOk = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			state          <= stc_pkg::STC_RESET;
			postIndex      <= '0;
			postStart      <= 1'b0;
			hostSelfTestOk <= 1'b0;
			errorFlag      <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			postIndex      <= next_postIndex;
			postStart      <= next_postStart;
			hostSelfTestOk <= next_hostSelfTestOk;
			errorFlag      <= next_errorFlag;
		end

	// Any role other than none counts as a logged-in operator
	function automatic logic roleActive(input logic [stc_pkg::ROLE_W-1:0] role);
		return role != stc_pkg::ROLE_NONE;
	endfunction

	// Output gate: only in ready, no conditional test running
	assign outOpen = (state == stc_pkg::STC_READY) && !condBusy && (next_state == state);

	always_comb
	begin
		next_activeRole   = activeRole;
		next_pwRefused    = 1'b0;
		next_cryptoEnable = (next_state == stc_pkg::STC_READY);
		if (next_state != stc_pkg::STC_READY || logout)
			next_activeRole = stc_pkg::ROLE_NONE;
		else if (pwValid && !pwEncrypted)
			next_pwRefused = 1'b1;
		else if (authOk && pwEncrypted)
			next_activeRole = authRole;
		next_serviceGrant = svcReq && next_cryptoEnable && svcProcessed
			&& (!svcSecret || roleActive(activeRole));
		next_dataOutValid = dataValid && outOpen && roleActive(activeRole);
		next_dataOut      = next_dataOutValid ? dataIn : '0;
		next_symKey       = (keyGenValid && outOpen) ? genBits : symKey;
		next_fwExecEnable = fwExecEnable;
		if (fwLoadDone)
			next_fwExecEnable = fwSigOk && outOpen;
		if (next_state == stc_pkg::STC_ERROR)
			next_fwExecEnable = 1'b0;
		next_versionValid = versionReq && !errorFlag;
		next_versionOut   = next_versionValid ? FW_VERSION : '0;
	end

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			activeRole   <= stc_pkg::ROLE_NONE;
			pwRefused    <= 1'b0;
			cryptoEnable <= 1'b0;
			serviceGrant <= 1'b0;
			dataOutValid <= 1'b0;
			dataOut      <= '0;
			symKey       <= '0;
			fwExecEnable <= 1'b0;
			versionValid <= 1'b0;
			versionOut   <= '0;
		end
		else
		begin
			activeRole   <= next_activeRole;
			pwRefused    <= next_pwRefused;
			cryptoEnable <= next_cryptoEnable;
			serviceGrant <= next_serviceGrant;
			dataOutValid <= next_dataOutValid;
			dataOut      <= next_dataOut;
			symKey       <= next_symKey;
			fwExecEnable <= next_fwExecEnable;
			versionValid <= next_versionValid;
			versionOut   <= next_versionOut;
		end

	assign ledOn   = hostSelfTestOk || errorFlag;
	assign ledFast = errorFlag;

	stc_flasher #(
		.OK_HALF  (OK_HALF),
		.ERR_HALF (ERR_HALF)
	) u_flash (
		.clk_sys (clk_sys),
		.reset   (reset),
		.enable  (ledOn),
		.fast    (ledFast),
		.led     (statusLed)
	);

	stc_key_check u_key (
		.clk_sys (clk_sys),
		.reset   (reset),
		.check   (xtsCheck),
		.keyA    (xtsKeyA),
		.keyB    (xtsKeyB),
		.done    (keyDone),
		.accept  (keyAccept)
	);

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			xtsDone   <= 1'b0;
			xtsAccept <= 1'b0;
		end
		else
		begin
			xtsDone   <= keyDone;
			xtsAccept <= keyAccept;
		end

	// Output gating
	a_gate_error: assert property (@(posedge clk_sys) disable iff (reset)
		errorFlag |-> !dataOutValid)
		else $error("Data out during error");
	a_gate_state: assert property (@(posedge clk_sys) disable iff (reset)
		state != stc_pkg::STC_READY |=> !dataOutValid)
		else $error("Data out outside ready");
	a_gate_busy: assert property (@(posedge clk_sys) disable iff (reset)
		condBusy |=> !dataOutValid)
		else $error("Data out during conditional test");
	a_data_auth: assert property (@(posedge clk_sys) disable iff (reset)
		!roleActive(activeRole) |=> !dataOutValid)
		else $error("Data out without login");

	// Error handling and power-up sequence
	a_error_services: assert property (@(posedge clk_sys) disable iff (reset)
		errorFlag |-> !cryptoEnable && !serviceGrant)
		else $error("Service in error");
	a_error_latched: assert property (@(posedge clk_sys) disable iff (reset)
		errorFlag |=> errorFlag)
		else $error("Error left");
	a_crypto_ready: assert property (@(posedge clk_sys) disable iff (reset)
		cryptoEnable == (state == stc_pkg::STC_READY))
		else $error("Crypto enable outside ready");
	a_post_fail: assert property (@(posedge clk_sys) disable iff (reset)
		state == stc_pkg::STC_POST && postDone && !postPass |=> errorFlag)
		else $error("Post failure missed");
	a_cond_fail: assert property (@(posedge clk_sys) disable iff (reset)
		state == stc_pkg::STC_READY && |condFail |=> errorFlag)
		else $error("Conditional failure missed");
	a_fw_error: assert property (@(posedge clk_sys) disable iff (reset)
		state == stc_pkg::STC_READY && fwLoadDone && !fwSigOk |=> errorFlag)
		else $error("Unsigned firmware not trapped");
	a_ok_not_error: assert property (@(posedge clk_sys) disable iff (reset)
		hostSelfTestOk |-> !errorFlag)
		else $error("Pass and error together");
	a_pass_ok: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(hostSelfTestOk) |-> $past(postIndex) == stc_pkg::POST_LAST)
		else $error("Pass before all tests");
	a_post_order: assert property (@(posedge clk_sys) disable iff (reset)
		state == stc_pkg::STC_POST && postDone && postPass && postIndex != stc_pkg::POST_LAST
		|=> postStart && postIndex == $past(postIndex) + 1'b1)
		else $error("Power-up tests out of order");

	// Authentication and services
	a_auth_drop: assert property (@(posedge clk_sys) disable iff (reset)
		errorFlag |-> activeRole == stc_pkg::ROLE_NONE)
		else $error("Role kept in error");
	a_role_fresh: assert property (@(posedge clk_sys) disable iff (reset)
		$changed(activeRole) && roleActive(activeRole)
		|-> $past(authOk) && $past(pwEncrypted))
		else $error("Role changed without login");
	a_no_plain_pw: assert property (@(posedge clk_sys) disable iff (reset)
		pwValid && !pwEncrypted && next_state == stc_pkg::STC_READY && !logout |=> pwRefused)
		else $error("Plaintext password not refused");
	a_secret_auth: assert property (@(posedge clk_sys) disable iff (reset)
		svcSecret && !roleActive(activeRole) |=> !serviceGrant)
		else $error("Secret service without login");
	a_bypass: assert property (@(posedge clk_sys) disable iff (reset)
		!svcProcessed |=> !serviceGrant)
		else $error("Service granted without processing");
	a_version_reply: assert property (@(posedge clk_sys) disable iff (reset)
		versionReq && !errorFlag |=> versionValid && versionOut == FW_VERSION)
		else $error("Version not reported");

	// Keys and firmware
	a_key_equal: assert property (@(posedge clk_sys) disable iff (reset)
		xtsCheck && xtsKeyA == xtsKeyB |-> ##2 xtsDone && !xtsAccept)
		else $error("Equal keys accepted");
	a_key_copy: assert property (@(posedge clk_sys) disable iff (reset)
		keyGenValid && outOpen |=> symKey == $past(genBits))
		else $error("Generated key altered");
	a_fw_unsigned: assert property (@(posedge clk_sys) disable iff (reset)
		fwLoadDone && !fwSigOk |=> !fwExecEnable)
		else $error("Unsigned firmware enabled");

	c_reach_ready: cover property (@(posedge clk_sys) $rose(hostSelfTestOk));
	c_reach_error: cover property (@(posedge clk_sys) $rose(errorFlag));
	c_data_out: cover property (@(posedge clk_sys) dataOutValid);
	c_zeroize: cover property (@(posedge clk_sys) state == stc_pkg::STC_ZERO);
	c_key_reject: cover property (@(posedge clk_sys) xtsDone && !xtsAccept);
endmodule // stc_self_test_ctrl

// ==== include/stc_pkg.sv ====
package stc_pkg;
	// Clock and LED flash timing
	localparam int CLK_HZ        = 125_000_000;
	localparam int OK_FLASH_HZ   = 3;
	localparam int ERR_FLASH_HZ  = 16;
	// Half period of each flash, in clock cycles (round down)
	localparam int OK_HALF_CYC   = CLK_HZ / (2 * OK_FLASH_HZ);
	localparam int ERR_HALF_CYC  = CLK_HZ / (2 * ERR_FLASH_HZ);
	localparam int FLASH_CNT_W   = 25;

	// Power-up tests, one index each, run in this order
	localparam int POST_COUNT    = 9;
	localparam int POST_IDX_W    = 4;
	localparam logic [POST_IDX_W-1:0] POST_FW_HASH   = 4'h0;
	localparam logic [POST_IDX_W-1:0] POST_LAST      = 4'h8;

	// Conditional tests, one bit each
	localparam int COND_COUNT    = 4;
	localparam int COND_DRBG     = 0;
	localparam int COND_ENTROPY  = 1;
	localparam int COND_FW_LOAD  = 2;
	localparam int COND_SECRETS  = 3;

	localparam int KEY_W         = 256;
	localparam int ROLE_W        = 2;
	localparam logic [ROLE_W-1:0] ROLE_NONE = 2'h0;

	typedef enum logic [4:0] {
		STC_RESET  = 5'h01,
		STC_POST   = 5'h02,
		STC_READY  = 5'h04,
		STC_ZERO   = 5'h08,
		STC_ERROR  = 5'h10
	} stc_state_t;
endpackage

// ==== rtl/stc_flasher.sv ====
`timescale 1ns/1ps
// Square wave generator; half period chosen by input
module stc_flasher #(
	parameter int OK_HALF  = stc_pkg::OK_HALF_CYC,
	parameter int ERR_HALF = stc_pkg::ERR_HALF_CYC
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic enable,
	input  wire logic fast,
	output logic      led
);
	logic [stc_pkg::FLASH_CNT_W-1:0] count;
	logic [stc_pkg::FLASH_CNT_W-1:0] next_count;
	logic                            next_led;
	logic [stc_pkg::FLASH_CNT_W-1:0] limit;

	always_comb
	begin
		limit      = fast ? stc_pkg::FLASH_CNT_W'(ERR_HALF - 1)
		                  : stc_pkg::FLASH_CNT_W'(OK_HALF - 1);
		next_count = count;
		next_led   = led;
		if (!enable)
		begin
			next_count = '0;
			next_led   = 1'b0;
		end
		else if (count >= limit)
		begin
			next_count = '0;
			next_led   = ~led;
		end
		else
			next_count = count + 1'b1;
	end

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			count <= '0;
			led   <= 1'b0;
		end
		else
		begin
			count <= next_count;
			led   <= next_led;
		end
endmodule // stc_flasher

// ==== rtl/stc_key_check.sv ====
`timescale 1ns/1ps
// Full width inequality check of an XTS key pair
module stc_key_check #(
	parameter int KW = stc_pkg::KEY_W
) (
	input  wire logic          clk_sys,
	input  wire logic          reset,
	input  wire logic          check,
	input  wire logic [KW-1:0] keyA,
	input  wire logic [KW-1:0] keyB,
	output logic               done,
	output logic               accept
);
	logic next_done;
	logic next_accept;

	always_comb
	begin
		next_done   = check;
		next_accept = check && (keyA != keyB);
	end

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			done   <= 1'b0;
			accept <= 1'b0;
		end
		else
		begin
			done   <= next_done;
			accept <= next_accept;
		end
endmodule // stc_key_check

// ==== verif/stc_post_model.sv ====
`timescale 1ns/1ps
// Power-up test engine: answers each start after a chosen delay
module stc_post_model (
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	input  wire logic                      postStart,
	input  wire logic [stc_pkg::POST_IDX_W-1:0] postIndex,
	input  wire logic [stc_pkg::POST_IDX_W-1:0] failIdx,
	input  wire logic [1:0]                delay,
	output logic                           postDone,
	output logic                           postPass
);
	logic v;
	initial
	begin
		postDone = 0;
		postPass = 0;
	end
	always @(negedge clk_sys)
	begin
		if (postStart === 1'b1 && !reset)
		begin
			v = (postIndex != failIdx);
			repeat (delay) @(posedge clk_sys);
			@(posedge clk_sys);
			#1 postDone = 1;
			postPass = v;
			@(posedge clk_sys);
			// Result is inverted once the strobe drops
			#1 postDone = 0;
			postPass = ~v;
		end
	end
endmodule // stc_post_model

// ==== verif/self_test_status_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module self_test_status_control_tb;
	logic clk_sys = 0, reset = 1, postStart, postDone, postPass, condBusy = 0;
	logic zeroReq = 0, zeroDone = 0, authOk = 0, logout = 0, pwEncrypted = 0;
	logic pwValid = 0, pwRefused, serviceGrant, svcReq = 0, svcProcessed = 0;
	logic svcSecret = 0, dataValid = 0, dataOutValid, keyGenValid = 0, xtsCheck = 0;
	logic xtsDone, xtsAccept, fwLoadDone = 0, fwSigOk = 0, fwExecEnable, versionReq = 0;
	logic versionValid, hostSelfTestOk, errorFlag, cryptoEnable, statusLed;
	logic [3:0] postIndex, failIdx = 4'hf, condFail = 4'h0, gi;
	logic [1:0] delay = 0, authRole = 0, activeRole;
	logic [31:0] dataIn = 0, dataOut, gd;
	logic [stc_pkg::KEY_W-1:0] genBits = 0, symKey, xtsKeyA = 0, xtsKeyB = 0;
	logic [15:0] versionOut;
	int n_fail = 0, tests_run = 0, seed = 32'he0b7, i;
	logic [31:0] expQ[$];
	logic [3:0] idxQ[$];
	stc_self_test_ctrl #(.OK_HALF(10), .ERR_HALF(4)) dut_u (.clk_sys, .reset, .postStart,
		.postIndex, .postDone, .postPass, .condFail, .condBusy, .zeroReq, .zeroDone,
		.authOk, .authRole, .logout, .pwEncrypted, .pwValid, .pwRefused, .activeRole,
		.serviceGrant, .svcReq, .svcProcessed, .svcSecret, .dataValid, .dataIn,
		.dataOutValid, .dataOut, .keyGenValid, .genBits, .symKey, .xtsCheck, .xtsKeyA,
		.xtsKeyB, .xtsDone, .xtsAccept, .fwLoadDone, .fwSigOk, .fwExecEnable,
		.versionReq, .versionValid, .versionOut, .hostSelfTestOk, .errorFlag,
		.cryptoEnable, .statusLed);
	stc_post_model post_u (.clk_sys, .reset, .postStart, .postIndex, .failIdx, .delay,
		.postDone, .postPass);
	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end
	// Output watcher: every result must match the oldest note
	always @(negedge clk_sys)
	begin
		if (dataOutValid === 1'b1)
		begin
			if (expQ.size() == 0)
				`CHK(dataOutValid, 1'b0)
			else
			begin
				gd = expQ.pop_front();
				`CHK(dataOut, gd)
			end
		end
		if (postStart === 1'b1)
		begin
			if (idxQ.size() == 0)
				`CHK(postStart, 1'b0)
			else
			begin
				gi = idxQ.pop_front();
				`CHK(postIndex, gi)
			end
		end
	end
	task tally_and_finish;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task clk1;
		@(posedge clk_sys);
		#1;
	endtask
	// Power cycle, with the given test failing; data offered all along
	task boot(input logic [3:0] f);
		failIdx = f;
		delay = 2'($random(seed));
		for (i = 0; i <= 8 && i <= f; i++)
			idxQ.push_back(i[3:0]);
		reset = 1;
		dataValid = 1;
		repeat (6) clk1;
		reset = 0;
		for (i = 0; i < 300 && !(hostSelfTestOk === 1'b1 || errorFlag === 1'b1); i++)
			clk1;
		dataValid = 0;
		if (i == 300)
		begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	task ledGap(input int e);
		int c;
		logic p;
		for (c = 0, p = statusLed; c < 200 && statusLed === p; c++)
			clk1;
		for (c = 0, p = statusLed; c < 200 && statusLed === p; c++)
			clk1;
		`CHK(c, e)
		if (c == 200)
			tally_and_finish;
	endtask
	// Encrypted login into the given role
	task login(input logic [1:0] r);
		{authOk, authRole, pwEncrypted} = {1'b1, r, 1'b1};
		clk1;
		authOk = 0;
	endtask
	initial
	begin
		boot(4'hf);
		`CHK({hostSelfTestOk, cryptoEnable, errorFlag, statusLed}, 4'b1100)
		ledGap(10);
		$display("power-up pass done");
		pwValid = 1;
		clk1;
		pwValid = 0;
		`CHK(pwRefused, 1'b1)
		{svcReq, svcProcessed, svcSecret} = 3'b111;
		clk1;
		`CHK(serviceGrant, 1'b0)
		{authOk, authRole, pwEncrypted} = 4'b1011;
		clk1;
		authOk = 0;
		`CHK(activeRole, 2'h1)
		clk1;
		`CHK(serviceGrant, 1'b1)
		{authOk, authRole, pwEncrypted} = 4'b1100;
		svcProcessed = 0;
		clk1;
		authOk = 0;
		`CHK(activeRole, 2'h1)
		`CHK(serviceGrant, 1'b0)
		svcReq = 0;
		logout = 1;
		clk1;
		logout = 0;
		`CHK(activeRole, 2'h0)
		login(2'h2);
		`CHK(activeRole, 2'h2)
		$display("auth done");
		for (i = 0; i < 8; i++)
		begin
			dataValid = 1;
			dataIn = $random(seed);
			expQ.push_back(dataIn);
			clk1;
		end
		condBusy = 1;
		repeat (3) clk1;
		condBusy = 0;
		zeroReq = 1;
		clk1;
		zeroReq = 0;
		dataValid = 1;
		repeat (2) clk1;
		{dataValid, zeroDone} = 2'b01;
		clk1;
		zeroDone = 0;
		$display("data gating done");
		keyGenValid = 1;
		genBits = {8{$random(seed)}};
		clk1;
		keyGenValid = 0;
		`CHK(symKey, genBits)
		for (i = 0; i < 3; i++)
		begin
			xtsKeyA = {8{$random(seed)}};
			xtsKeyB = xtsKeyA ^ (i == 0 ? 0 : i == 1 ? 1 : {1'b1, 255'h0});
			xtsCheck = 1;
			clk1;
			xtsCheck = 0;
			clk1;
			`CHK({xtsDone, xtsAccept}, {1'b1, i != 0})
		end
		versionReq = 1;
		clk1;
		versionReq = 0;
		`CHK({versionValid, versionOut}, 17'h10001)
		{fwLoadDone, fwSigOk} = 2'b11;
		clk1;
		fwLoadDone = 0;
		`CHK(fwExecEnable, 1'b1)
		$display("services done");
		login(2'h1);
		condFail = 4'h1 << ($random(seed) & 3);
		dataValid = 1;
		clk1;
		condFail = 0;
		`CHK({errorFlag, cryptoEnable, hostSelfTestOk}, 3'b100)
		{dataValid, versionReq} = 2'b11;
		clk1;
		{dataValid, versionReq} = 2'b00;
		`CHK(versionValid, 1'b0)
		ledGap(4);
		`CHK(errorFlag, 1'b1)
		$display("conditional failure done");
		boot(4'($unsigned($random(seed)) % 9));
		`CHK({errorFlag, cryptoEnable, activeRole}, 4'b1000)
		ledGap(4);
		boot(4'hf);
		`CHK({hostSelfTestOk, activeRole}, 3'b100)
		login(2'h1);
		`CHK(activeRole, 2'h1)
		boot(4'hf);
		`CHK(activeRole, 2'h0)
		{fwLoadDone, fwSigOk} = 2'b10;
		clk1;
		fwLoadDone = 0;
		`CHK({errorFlag, fwExecEnable}, 2'b10)
		$display("power cycles done");
		`CHK(expQ.size() + idxQ.size(), 0)
		tally_and_finish;
	end
endmodule // self_test_status_control_tb
